// ==== hdl/cpu_mem_pkg.sv ====
// Shared constants and types for the CPU memory access unit
package cpu_mem_pkg;
	// Datapath and address widths
	localparam int WORD_W     = 24;
	localparam int DWORD_W    = 48;
	localparam int BYTE_W     = 8;
	localparam int PADDR_W    = 18;
	localparam int PC_W       = 16;
	localparam int PAGE_OFS_W = 10;
	localparam int PAGE_SEL_W = 6;
	localparam int FRAME_W    = 8;
	localparam int SECT_OFS_W = 15;
	localparam int SECT_W     = 3;
	localparam int NUM_PAGES  = 64;
	localparam int NUM_GR     = 6;
	localparam int GR_SEL_W   = 3;
	localparam int SUB_W      = 5;

	// Designated general registers
	localparam logic [GR_SEL_W-1:0] REG_IO   = 3'h0;
	localparam logic [GR_SEL_W-1:0] REG_DHI  = 3'h1;
	localparam logic [GR_SEL_W-1:0] REG_DLO  = 3'h2;
	localparam logic [GR_SEL_W-1:0] REG_BYTE = 3'h3;
	localparam logic [GR_SEL_W-1:0] REG_T    = 3'h5;

	// Reset values and sub-word limits
	localparam logic [PC_W-1:0]  PC_RST   = 16'h0000;
	localparam logic [SUB_W-1:0] BIT_MAX  = 5'h17;
	localparam logic [1:0]       BYTE_MAX = 2'h2;

	typedef enum logic [1:0] {G_WORD, G_DWORD, G_BYTE, G_BIT} gran_t;
	typedef enum logic [2:0] {SRC_MAR, SRC_PC, SRC_ALU, SRC_OPND, SRC_BLK} addr_src_t;
	typedef enum logic [2:0] {OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_SQRT} alu_op_t;
	typedef enum {ST_IDLE, ST_RD, ST_WR, ST_DONE} mem_state_t;
endpackage

// ==== hdl/alu_unit.sv ====
// Combinational 24-bit two's complement arithmetic unit
`timescale 1ns/10ps
`default_nettype none
module alu_unit
	import cpu_mem_pkg::*;
(
	input  wire logic [WORD_W-1:0] a,
	input  wire logic [WORD_W-1:0] b,
	input  wire alu_op_t           op,
	output logic [WORD_W-1:0]      y
);
	logic [DWORD_W-1:0] prod;
	logic [DWORD_W-1:0] sq;
	logic [WORD_W-1:0]  mag;
	logic [WORD_W-1:0]  root;
	logic [WORD_W-1:0]  trial;

	// Square root works on the magnitude; a bit-serial loop keeps the
	// result exact at the cost of a long combinational path
	always_comb begin
		prod  = DWORD_W'($signed(a) * $signed(b));
		mag   = a[WORD_W-1] ? WORD_W'(-a) : a;
		root  = '0;
		trial = '0;
		sq    = '0;
		for (int i = WORD_W/2-1; i >= 0; i--) begin
			trial = root | (WORD_W'(1) << i);
			sq    = DWORD_W'(trial * trial);
			if (sq <= DWORD_W'(mag)) begin
				root = trial;
			end
		end
		case (op)
			OP_ADD:  y = a + b;
			OP_SUB:  y = a - b;
			OP_MUL:  y = prod[WORD_W-1:0];
			OP_DIV:  y = (b == '0) ? '0 : WORD_W'($signed(a) / $signed(b));
			OP_SQRT: y = root;
			default: y = '0;
		endcase
	end
endmodule // alu_unit
`default_nettype wire

// ==== hdl/mem_access_unit.sv ====
// CPU memory access unit: registers, address selection, paging, memory cycle
`timescale 1ns/10ps
`default_nettype none
// How it works
// - General registers, the operand register and arithmetic carry 24-bit words.
// - Memory is always addressed at an even word, returning a word pair.
// - Memory cycle waits in place until memory acknowledges.
// - Accesses may be word, double word, byte or single bit.
// - Virtual memory off: physical memory seen as 32K word sections.
// - Instruction fetch addresses span at most 65,536 words.
// - User mode address splits into page and offset; page maps to 1K frame.
// - Reference to a non-resident page raises a page fault.
// - Monitor mode addresses go to memory untranslated.
// - Timer register usable in monitor mode, hidden in user mode.
// - Two general registers join to form a double-word operand.
// - Byte register is the low eight bits of one general register.
// - Three registers index addresses; one carries single-word I/O data.
// - 48-bit data register and 18-bit address register face memory.
// - Parity is generated on writes and checked on reads.
// - Address comes from MAR, PC, ALU, operand, block channel or paging.
// - Arithmetic unit does add, subtract, multiply, divide, square root.
// - Instruction register holds the word until the next fetch ends.
module mem_access_unit
	import cpu_mem_pkg::*;
(
	input  wire logic                  sys_clk,
	input  wire logic                  rst_n,
	input  wire logic                  vm_enable,
	input  wire logic                  monitor_mode,
	input  wire logic [SECT_W-1:0]     section_sel,
	input  wire logic                  req_valid,
	output logic                       req_ready,
	input  wire logic                  req_fetch,
	input  wire logic                  req_write,
	input  wire gran_t                 req_gran,
	input  wire addr_src_t             req_src,
	input  wire logic [GR_SEL_W-1:0]   req_reg,
	input  wire logic [1:0]            req_idx,
	input  wire logic [SUB_W-1:0]      req_sub,
	output logic                       req_done,
	input  wire logic                  mar_load,
	input  wire logic [PADDR_W-1:0]    mar_in,
	input  wire logic                  opnd_load,
	input  wire logic [WORD_W-1:0]     opnd_in,
	input  wire logic [PADDR_W-1:0]    blk_addr,
	input  wire logic                  pc_load,
	input  wire logic [PC_W-1:0]       pc_in,
	input  wire logic                  alu_go,
	input  wire alu_op_t               alu_op,
	input  wire logic [GR_SEL_W-1:0]   alu_asel,
	output logic [WORD_W-1:0]          alu_result,
	input  wire logic                  rf_we,
	input  wire logic [GR_SEL_W-1:0]   rf_wsel,
	input  wire logic [WORD_W-1:0]     rf_wdata,
	input  wire logic [GR_SEL_W-1:0]   rf_rsel,
	output logic [WORD_W-1:0]          rf_rdata,
	output logic [DWORD_W-1:0]         dword_out,
	output logic [BYTE_W-1:0]          byte_out,
	output logic [WORD_W-1:0]          io_word,
	output logic [WORD_W-1:0]          instr_word,
	output logic [PC_W-1:0]            pc_out,
	input  wire logic                  pt_we,
	input  wire logic [PAGE_SEL_W-1:0] pt_idx,
	input  wire logic [FRAME_W-1:0]    pt_frame,
	input  wire logic                  pt_present,
	output logic                       page_fault,
	output logic [PAGE_SEL_W-1:0]      fault_page,
	output logic                       priv_err,
	output logic                       parity_err,
	output logic                       mem_req,
	output logic                       mem_we,
	output logic [PADDR_W-1:0]         mem_addr,
	output logic [DWORD_W-1:0]         mem_wdata,
	output logic [1:0]                 mem_wpar,
	input  wire logic [DWORD_W-1:0]    mem_rdata,
	input  wire logic [1:0]            mem_rpar,
	input  wire logic                  mem_ack
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////
	// State declarations
	mem_state_t          state_r, state_nxt;
	logic [PADDR_W-1:0]  addr_r, addr_nxt;
	logic [DWORD_W-1:0]  mdr_r, mdr_nxt;
	logic [DWORD_W-1:0]  wdat_r, wdat_nxt;
	logic [WORD_W-1:0]   ir_r, ir_nxt;
	logic [PC_W-1:0]     pc_r, pc_nxt;
	logic                odd_r, odd_nxt;
	logic                cwr_r, cwr_nxt;
	logic                cfetch_r, cfetch_nxt;
	gran_t               cgran_r, cgran_nxt;
	logic [GR_SEL_W-1:0] creg_r, creg_nxt;
	logic [SUB_W-1:0]    csub_r, csub_nxt;
	logic                pf_vld_r, pf_vld_nxt;
	logic [PC_W-1:0]     pf_pc_r, pf_pc_nxt;
	logic [WORD_W-1:0]   pf_word_r, pf_word_nxt;
	logic                done_r, done_nxt;
	logic                fault_r, fault_nxt;
	logic [PAGE_SEL_W-1:0] fpage_r, fpage_nxt;
	logic                perr_r, perr_nxt;
	logic                priv_r, priv_nxt;
	logic [WORD_W-1:0]   gr_r [NUM_GR];
	logic [WORD_W-1:0]   gr_nxt [NUM_GR];
	logic [WORD_W-1:0]   rdata_r, rdata_nxt;
	logic [PADDR_W-1:0]  mar_r, mar_nxt;
	logic [WORD_W-1:0]   opnd_r, opnd_nxt;
	logic [WORD_W-1:0]   alu_y_r, alu_y_nxt;
	logic [FRAME_W-1:0]  pt_frame_r [NUM_PAGES];
	logic                pt_present_r [NUM_PAGES];
	logic [DWORD_W-1:0]  dword_r;
	logic [BYTE_W-1:0]   byte_r;
	logic [WORD_W-1:0]   io_r;

	// Combinational helpers
	logic                acc, user, user_xl, fault, pf_hit, t_mem, go;
	logic [PADDR_W-1:0]  src_la, idx_val, ea, phys;
	logic [FRAME_W-1:0]  pte_frame;
	logic [WORD_W-1:0]   alu_y, ld_word, st_word;
	logic [1:0]          byte_i, rpar_calc;
	logic [SUB_W-1:0]    bit_i;

	////////////////////////////////////////////////////////////////////////
	// Arithmetic unit; its registered result is one of the address sources
	alu_unit u_alu (
		.a  (gr_r[alu_asel]),
		.b  (opnd_r),
		.op (alu_op),
		.y  (alu_y)
	);

	////////////////////////////////////////////////////////////////////////
	// Address source selection, indexing and translation
	always_comb begin
		case (req_src)
			SRC_MAR:  src_la = mar_r;
			SRC_PC:   src_la = {2'b00, pc_r};
			SRC_ALU:  src_la = alu_y_r[PADDR_W-1:0];
			SRC_OPND: src_la = opnd_r[PADDR_W-1:0];
			SRC_BLK:  src_la = blk_addr;
			default:  src_la = mar_r;
		endcase
		if (req_fetch) begin
			src_la = {2'b00, pc_r};
		end
		// Only registers 1..3 index; a zero field means no indexing
		idx_val = (req_idx != 2'b00 && !req_fetch) ? gr_r[{1'b0, req_idx}][PADDR_W-1:0] : '0;
		ea = src_la + idx_val;
	end

	assign user      = !monitor_mode;
	assign user_xl   = vm_enable && user;
	assign pte_frame = pt_frame_r[ea[PAGE_OFS_W+PAGE_SEL_W-1:PAGE_OFS_W]];
	assign fault     = user_xl && !pt_present_r[ea[PAGE_OFS_W+PAGE_SEL_W-1:PAGE_OFS_W]];

	// Physical address: section, translated page, or straight through
	always_comb begin
		if (!vm_enable) begin
			phys = {section_sel, ea[SECT_OFS_W-1:0]};
		end else if (user_xl) begin
			phys = {pte_frame, ea[PAGE_OFS_W-1:0]};
		end else begin
			phys = ea;
		end
	end

	assign req_ready = (state_r == ST_IDLE);
	assign acc       = req_valid && req_ready;
	assign pf_hit    = req_fetch && pf_vld_r && (pf_pc_r == pc_r);
	assign t_mem     = user && !req_fetch && req_gran != G_DWORD && req_reg == REG_T;
	assign go        = acc && !pf_hit && !t_mem && !fault;

	////////////////////////////////////////////////////////////////////////
	// Sub-word extraction and merge; bit selectors clamp, byte selectors clamp only their low two bits
	assign byte_i  = (req_sub[1:0] > BYTE_MAX) ? BYTE_MAX : req_sub[1:0];
	assign bit_i   = (csub_r > BIT_MAX) ? BIT_MAX : csub_r;
	assign ld_word = odd_r ? mdr_r[WORD_W-1:0] : mdr_r[DWORD_W-1:WORD_W];

	always_comb begin
		st_word = odd_r ? mem_rdata[WORD_W-1:0] : mem_rdata[DWORD_W-1:WORD_W];
		case (cgran_r)
			G_BYTE:  st_word[{csub_r[1:0], 3'b000} +: BYTE_W] = wdat_r[BYTE_W-1:0];
			G_BIT:   st_word[bit_i] = wdat_r[0];
			default: st_word = wdat_r[WORD_W-1:0];
		endcase
	end

	// Parity per word, even sense
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_par
			assign mem_wpar[gi]  = ^mdr_r[gi*WORD_W +: WORD_W];
			assign rpar_calc[gi] = ^mem_rdata[gi*WORD_W +: WORD_W];
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Memory cycle sequencer: read, optional merge and write back, finish.
	// Every write is a read-modify-write because memory moves whole pairs.
	always_comb begin
		state_nxt = state_r;
		addr_nxt = addr_r;
		mdr_nxt = mdr_r;
		wdat_nxt = wdat_r;
		ir_nxt = ir_r;
		pc_nxt = pc_load ? pc_in : pc_r;
		odd_nxt = odd_r;
		cwr_nxt = cwr_r;
		cfetch_nxt = cfetch_r;
		cgran_nxt = cgran_r;
		creg_nxt = creg_r;
		csub_nxt = csub_r;
		pf_vld_nxt = pf_vld_r && !pc_load && !pt_we;
		pf_pc_nxt = pf_pc_r;
		pf_word_nxt = pf_word_r;
		done_nxt = 1'b0;
		fault_nxt = 1'b0;
		fpage_nxt = fpage_r;
		perr_nxt = 1'b0;
		case (state_r)
			ST_IDLE: if (acc) begin
				if (pf_hit) begin
					ir_nxt = pf_word_r;
					pc_nxt = pc_r + 16'h0001;
					pf_vld_nxt = 1'b0;
					done_nxt = 1'b1;
				end else if (t_mem) begin
					done_nxt = 1'b0;
				end else if (fault) begin
					fault_nxt = 1'b1;
					fpage_nxt = ea[PAGE_OFS_W+PAGE_SEL_W-1:PAGE_OFS_W];
				end else begin
					addr_nxt = {phys[PADDR_W-1:1], 1'b0};
					odd_nxt = phys[0];
					cwr_nxt = req_write && !req_fetch;
					cfetch_nxt = req_fetch;
					cgran_nxt = req_fetch ? G_WORD : req_gran;
					creg_nxt = req_reg;
					csub_nxt = (req_gran == G_BYTE) ? {3'b000, byte_i} : req_sub;
					wdat_nxt = (req_gran == G_DWORD) ? {gr_r[REG_DHI], gr_r[REG_DLO]}
					                                 : {24'h000000, gr_r[req_reg]};
					if (req_write) begin
						pf_vld_nxt = 1'b0;
					end
					state_nxt = ST_RD;
				end
			end
			ST_RD: if (mem_ack) begin
				perr_nxt = (rpar_calc != mem_rpar);
				if (!cwr_r) begin
					mdr_nxt = mem_rdata;
					state_nxt = ST_DONE;
				end else begin
					if (cgran_r == G_DWORD) begin
						mdr_nxt = wdat_r;
					end else if (odd_r) begin
						mdr_nxt = {mem_rdata[DWORD_W-1:WORD_W], st_word};
					end else begin
						mdr_nxt = {st_word, mem_rdata[WORD_W-1:0]};
					end
					state_nxt = ST_WR;
				end
			end
			ST_WR: if (mem_ack) begin
				state_nxt = ST_DONE;
			end
			ST_DONE: begin
				done_nxt = 1'b1;
				state_nxt = ST_IDLE;
				if (cfetch_r) begin
					ir_nxt = ld_word;
					pc_nxt = pc_r + 16'h0001;
					// The odd half of an even pair is the next instruction
					pf_vld_nxt = !odd_r;
					pf_pc_nxt = pc_r + 16'h0001;
					pf_word_nxt = mdr_r[WORD_W-1:0];
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			addr_r <= '0;
			mdr_r <= '0;
			wdat_r <= '0;
			ir_r <= '0;
			pc_r <= PC_RST;
			odd_r <= 1'b0;
			cwr_r <= 1'b0;
			cfetch_r <= 1'b0;
			cgran_r <= G_WORD;
			creg_r <= '0;
			csub_r <= '0;
			pf_vld_r <= 1'b0;
			pf_pc_r <= PC_RST;
			pf_word_r <= '0;
			done_r <= 1'b0;
			fault_r <= 1'b0;
			fpage_r <= '0;
			perr_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			addr_r <= addr_nxt;
			mdr_r <= mdr_nxt;
			wdat_r <= wdat_nxt;
			ir_r <= ir_nxt;
			pc_r <= pc_nxt;
			odd_r <= odd_nxt;
			cwr_r <= cwr_nxt;
			cfetch_r <= cfetch_nxt;
			cgran_r <= cgran_nxt;
			creg_r <= creg_nxt;
			csub_r <= csub_nxt;
			pf_vld_r <= pf_vld_nxt;
			pf_pc_r <= pf_pc_nxt;
			pf_word_r <= pf_word_nxt;
			done_r <= done_nxt;
			fault_r <= fault_nxt;
			fpage_r <= fpage_nxt;
			perr_r <= perr_nxt;
		end
	end

	assign mem_req   = (state_r == ST_RD) || (state_r == ST_WR);
	assign mem_we    = (state_r == ST_WR);
	assign mem_addr  = addr_r;
	assign mem_wdata = mdr_r;

	chk_addr_aligned: assert property (mem_req |-> !mem_addr[0]) else $error("odd pair address");
	chk_stall_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
		else $error("cycle moved before ack");
	chk_page_map: assert property (go && user_xl |=>
		mem_addr[PAGE_OFS_W-1:1] == $past(ea[PAGE_OFS_W-1:1]) && mem_addr[PADDR_W-1:PAGE_OFS_W] == $past(pte_frame))
		else $error("page translation wrong");
	chk_mon_bypass: assert property (go && vm_enable && monitor_mode |=> mem_addr[PADDR_W-1:1] == $past(ea[PADDR_W-1:1]))
		else $error("monitor address altered");
	chk_section_map: assert property (go && !vm_enable |=> mem_addr[PADDR_W-1:SECT_OFS_W] == $past(section_sel))
		else $error("section select lost");
	chk_fault_raise: assert property (acc && fault && !pf_hit && !t_mem |=> page_fault && !mem_req && !req_done)
		else $error("faulting access went on");
	chk_wr_parity: assert property (mem_we |-> mem_wpar == {^mem_wdata[DWORD_W-1:WORD_W], ^mem_wdata[WORD_W-1:0]})
		else $error("write parity wrong");
	chk_ir_hold: assert property (state_r == ST_RD || state_r == ST_WR |=> $stable(instr_word))
		else $error("instruction changed mid cycle");

	////////////////////////////////////////////////////////////////////////
	// General registers: memory loads win over the direct write port
	always_comb begin
		gr_nxt = gr_r;
		priv_nxt = 1'b0;
		rdata_nxt = '0;
		if (rf_we && rf_wsel < GR_SEL_W'(NUM_GR)) begin
			if (user && rf_wsel == REG_T) begin
				priv_nxt = 1'b1;
			end else begin
				gr_nxt[rf_wsel] = rf_wdata;
			end
		end
		if (state_r == ST_DONE && !cwr_r && !cfetch_r) begin
			case (cgran_r)
				G_DWORD: begin
					gr_nxt[REG_DHI] = mdr_r[DWORD_W-1:WORD_W];
					gr_nxt[REG_DLO] = mdr_r[WORD_W-1:0];
				end
				G_BYTE:  gr_nxt[creg_r] = {16'h0000, ld_word[{csub_r[1:0], 3'b000} +: BYTE_W]};
				G_BIT:   gr_nxt[creg_r] = {23'h000000, ld_word[bit_i]};
				default: gr_nxt[creg_r] = ld_word;
			endcase
		end
		if (user && rf_rsel == REG_T) begin
			priv_nxt = 1'b1;
		end else if (rf_rsel < GR_SEL_W'(NUM_GR)) begin
			rdata_nxt = gr_r[rf_rsel];
		end
		if (acc && !pf_hit && t_mem) begin
			priv_nxt = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			gr_r <= '{default: '0};
			rdata_r <= '0;
			priv_r <= 1'b0;
			dword_r <= '0;
			byte_r <= '0;
			io_r <= '0;
		end else begin
			gr_r <= gr_nxt;
			rdata_r <= rdata_nxt;
			priv_r <= priv_nxt;
			dword_r <= {gr_r[REG_DHI], gr_r[REG_DLO]};
			byte_r <= gr_r[REG_BYTE][BYTE_W-1:0];
			io_r <= gr_r[REG_IO];
		end
	end

	chk_timer_hidden: assert property (user && rf_rsel == REG_T |=> rf_rdata == '0 && priv_err)
		else $error("timer visible in user mode");
	chk_dword_pair: assert property (1'b1 |=> dword_out == {$past(gr_r[REG_DHI]), $past(gr_r[REG_DLO])})
		else $error("double word pairing wrong");

	////////////////////////////////////////////////////////////////////////
	// Operand, address and arithmetic result registers
	always_comb begin
		mar_nxt = mar_load ? mar_in : mar_r;
		opnd_nxt = opnd_load ? opnd_in : opnd_r;
		alu_y_nxt = (alu_go && !(user && alu_asel == REG_T)) ? alu_y : alu_y_r;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			mar_r <= '0;
			opnd_r <= '0;
			alu_y_r <= '0;
		end else begin
			mar_r <= mar_nxt;
			opnd_r <= opnd_nxt;
			alu_y_r <= alu_y_nxt;
		end
	end

	// Page table; loaded through pt_we in either mode, all pages absent after reset
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pt_frame_r <= '{default: '0};
			pt_present_r <= '{default: 1'b0};
		end else if (pt_we) begin
			pt_frame_r[pt_idx] <= pt_frame;
			pt_present_r[pt_idx] <= pt_present;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output drive
	assign req_done   = done_r;
	assign page_fault = fault_r;
	assign fault_page = fpage_r;
	assign parity_err = perr_r;
	assign priv_err   = priv_r;
	assign rf_rdata   = rdata_r;
	assign dword_out  = dword_r;
	assign byte_out   = byte_r;
	assign io_word    = io_r;
	assign instr_word = ir_r;
	assign pc_out     = pc_r;
	assign alu_result = alu_y_r;
endmodule // mem_access_unit
`default_nettype wire

// ==== verif/mem_model.sv ====
// Behavioural main memory answering the access unit one double word at a time
`timescale 1ns/10ps
`default_nettype none
module mem_model
	import cpu_mem_pkg::*;
(
	input  wire logic               sys_clk,
	input  wire logic               mem_req,
	input  wire logic               mem_we,
	input  wire logic [PADDR_W-1:0] mem_addr,
	input  wire logic [DWORD_W-1:0] mem_wdata,
	input  wire logic [3:0]         wait_cyc,
	input  wire logic               bad_par,
	output logic [DWORD_W-1:0]      mem_rdata,
	output logic [1:0]              mem_rpar,
	output logic                    mem_ack
);
	logic [DWORD_W-1:0] store [int];
	logic [DWORD_W-1:0] pair;
	logic [3:0]         cnt_r = 4'h0;
	initial begin
		mem_ack = 1'h0;
		mem_rdata = '0;
		mem_rpar = 2'h0;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Busy module: each phase is stretched by wait_cyc, so contention is seen
	// Unwritten pairs read back as a tag plus each word's own address
	always @(posedge sys_clk) begin
		if (mem_req && !mem_ack && cnt_r == wait_cyc) begin
			mem_ack <= 1'h1;
			if (mem_we)
				store[int'(mem_addr[17:1])] = mem_wdata;
			pair = store.exists(int'(mem_addr[17:1])) ? store[int'(mem_addr[17:1])] :
				{6'h15, mem_addr[17:1], 1'h0, 6'h15, mem_addr[17:1], 1'h1};
			mem_rdata <= pair;
			mem_rpar <= {^pair[47:24] ^ bad_par, ^pair[23:0]};
		end else begin
			mem_ack <= 1'h0;
			cnt_r <= (mem_req && !mem_ack) ? cnt_r + 4'h1 : 4'h0;
			mem_rdata <= ~mem_rdata; // Released bus inverts its last data every cycle
		end
	end
endmodule // mem_model
`default_nettype wire

// ==== verif/tb_mem_access_unit.sv ====
// Self-checking bench for the memory access unit
`timescale 1ns/10ps
`default_nettype none
module tb_mem_access_unit
	import cpu_mem_pkg::*;
();
	logic sys_clk, rst_n, vm_enable, monitor_mode, req_valid, req_fetch, req_write, mar_load, opnd_load;
	logic pc_load, alu_go, rf_we, pt_we, pt_present, bad_par, req_ready, req_done, page_fault, priv_err;
	logic parity_err, mem_req, mem_we, mem_ack, parf;
	logic [SECT_W-1:0]     section_sel;
	gran_t                 req_gran;
	addr_src_t             req_src;
	alu_op_t               alu_op;
	logic [GR_SEL_W-1:0]   req_reg, alu_asel, rf_wsel, rf_rsel;
	logic [1:0]            req_idx, mem_wpar, mem_rpar;
	logic [SUB_W-1:0]      req_sub;
	logic [PADDR_W-1:0]    mar_in, blk_addr, mem_addr, cap, m, ph;
	logic [WORD_W-1:0]     opnd_in, rf_wdata, alu_result, rf_rdata, io_word, instr_word, e, a, b, w;
	logic [WORD_W-1:0]     v [6];
	logic [PC_W-1:0]       pc_in, pc_out;
	logic [DWORD_W-1:0]    dword_out, mem_wdata, mem_rdata;
	logic [BYTE_W-1:0]     byte_out;
	logic [PAGE_SEL_W-1:0] pt_idx, fault_page;
	logic [FRAME_W-1:0]    pt_frame;
	logic [3:0]            wait_cyc;
	logic [31:0]           rnd;
	logic [20:0]           notes [$];
	logic [4:0]            sb;
	int                    mismatches, checked, sq;

	mem_access_unit dut (.sys_clk, .rst_n, .vm_enable, .monitor_mode, .section_sel, .req_valid, .req_ready,
		.req_fetch, .req_write, .req_gran, .req_src, .req_reg, .req_idx, .req_sub, .req_done, .mar_load, .mar_in,
		.opnd_load, .opnd_in, .blk_addr, .pc_load, .pc_in, .alu_go, .alu_op, .alu_asel, .alu_result, .rf_we,
		.rf_wsel, .rf_wdata, .rf_rsel, .rf_rdata, .dword_out, .byte_out, .io_word, .instr_word, .pc_out, .pt_we,
		.pt_idx, .pt_frame, .pt_present, .page_fault, .fault_page, .priv_err, .parity_err, .mem_req, .mem_we,
		.mem_addr, .mem_wdata, .mem_wpar, .mem_rdata, .mem_rpar, .mem_ack);
	mem_model mem (.sys_clk, .mem_req, .mem_we, .mem_addr, .mem_wdata, .wait_cyc, .bad_par, .mem_rdata,
		.mem_rpar, .mem_ack);

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Content the memory model holds at an unwritten word
	function automatic logic [23:0] word(input logic [17:0] p);
		return {6'h15, p};
	endfunction
	task automatic cmp(input string nm, input logic [47:0] ex, input logic [47:0] got);
		checked++;
		if (got !== ex) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic conclude();
		if (mismatches == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic wr(input logic [2:0] s, input logic [23:0] d);
		@(posedge sys_clk);
		rf_we <= 1'h1;
		rf_wsel <= s;
		rf_wdata <= d;
		@(posedge sys_clk);
		rf_we <= 1'h0;
	endtask
	task automatic rd(input logic [2:0] s, input logic [23:0] ex);
		@(posedge sys_clk);
		rf_rsel <= s;
		cyc(2);
		#1 cmp("rf_rdata", 48'(ex), 48'(rf_rdata));
	endtask
	task automatic setmar(input logic [17:0] d);
		@(posedge sys_clk);
		mar_load <= 1'h1;
		mar_in <= d;
		@(posedge sys_clk);
		mar_load <= 1'h0;
	endtask
	// Note the expected event first, then hold the request until it is taken
	task automatic acc(input logic f, input logic wt, input gran_t g, input addr_src_t s, input logic [2:0] r,
		input logic [4:0] su, input logic [1:0] code, input logic [17:0] ea, input logic ep);
		notes.push_back({ep, code, ea});
		@(posedge sys_clk);
		req_valid <= 1'h1;
		req_fetch <= f;
		req_write <= wt;
		req_gran <= g;
		req_src <= s;
		req_reg <= r;
		req_sub <= su;
		do
			@(posedge sys_clk);
		while (!req_ready);
		req_valid <= 1'h0;
		while (notes.size() != 0)
			@(posedge sys_clk);
		@(posedge sys_clk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Result watcher: the oldest note is matched against each completion or refusal
	always @(posedge sys_clk) begin
		logic [20:0] nt;
		if (mem_req)
			cap = mem_addr;
		parf = parf | parity_err;
		if (mem_ack && mem_we)
			cmp("mem_wpar", {46'h0, ^mem_wdata[47:24], ^mem_wdata[23:0]}, 48'(mem_wpar));
		if (rst_n && (req_done || page_fault || priv_err)) begin
			nt = notes.size() != 0 ? notes.pop_front() : 21'h1FFFFF;
			cmp("event", 48'(nt[19:18]), 48'({page_fault | priv_err, priv_err | req_done}));
			cmp("mem_addr", 48'(nt[17:0]), 48'(cap));
			cmp("parity_err", 48'(nt[20]), 48'(parf));
			cap = '0;
			parf = 1'h0;
		end
	end
	initial begin
		sys_clk = 1'h0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// Watchdog sized well beyond the longest expected run
	initial begin
		cyc(20000);
		mismatches++;
		conclude();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{rst_n, req_valid, req_fetch, req_write, mar_load, opnd_load, pc_load, alu_go, rf_we, pt_we} = '0;
		{pt_present, bad_par, section_sel, req_reg, alu_asel, rf_wsel, rf_rsel, req_idx, req_sub} = '0;
		{mar_in, blk_addr, opnd_in, rf_wdata, pc_in, pt_idx, pt_frame, wait_cyc, cap, parf} = '0;
		{vm_enable, monitor_mode} = 2'h3;
		req_gran = G_WORD;
		req_src = SRC_MAR;
		alu_op = OP_ADD;
		rnd = 32'h6e56;
		cyc(16);
		#1 cmp("reset", 48'h20000, 48'({req_ready, mem_req, pc_out}));
		rst_n <= 1'h1;
		// General registers and their fixed views
		for (int i = 0; i < 6; i++) begin
			rnd = lfsr(rnd);
			v[i] = rnd[23:0];
			wr(3'(i), v[i]);
		end
		cyc(2);
		cmp("io_word", 48'(v[0]), 48'(io_word));
		cmp("dword_out", {v[1], v[2]}, dword_out);
		cmp("byte_out", 48'(v[3][7:0]), 48'(byte_out));
		for (int i = 0; i < 6; i++)
			rd(3'(i), v[i]);
		// Arithmetic unit, every operation on gr4 and the operand register
		a = {12'h0, rnd[11:0]};
		b = {16'h0, rnd[19:12] | 8'h01};
		sq = 0;
		while ((sq + 1) * (sq + 1) <= int'(a))
			sq++;
		wr(3'h4, a);
		@(posedge sys_clk);
		opnd_load <= 1'h1;
		opnd_in <= b;
		@(posedge sys_clk);
		opnd_load <= 1'h0;
		for (int k = 0; k < 5; k++) begin
			case (k)
				0: e = a + b;
				1: e = a - b;
				2: e = a * b;
				3: e = a / b;
				default: e = 24'(sq);
			endcase
			@(posedge sys_clk);
			alu_go <= 1'h1;
			alu_op <= alu_op_t'(k);
			alu_asel <= 3'h4;
			@(posedge sys_clk);
			alu_go <= 1'h0;
			@(posedge sys_clk);
			#1 cmp("alu_result", 48'(e), 48'(alu_result));
		end
		// Fetch from an even word, then the prefetched odd word without memory
		wait_cyc <= 4'h3;
		@(posedge sys_clk);
		pc_load <= 1'h1;
		pc_in <= 16'h1234;
		@(posedge sys_clk);
		pc_load <= 1'h0;
		for (int k = 0; k < 2; k++) begin
			acc(1'h1, 1'h0, G_WORD, SRC_PC, 3'h0, 5'h0, 2'h1, k ? 18'h0 : 18'h01234, 1'h0);
			cmp("instr_word", 48'(word(18'h01234 + 18'(k))), 48'(instr_word));
			cmp("pc_out", 48'(16'h1235 + 16'(k)), 48'(pc_out));
		end
		// Word loads: direct, block channel, sectioned, slow memory and a parity fault
		for (int k = 0; k < 6; k++) begin
			rnd = lfsr(rnd);
			m = rnd[17:0];
			wait_cyc <= rnd[21:18];
			req_idx <= k ? 2'h0 : 2'h3;
			vm_enable <= k < 4;
			section_sel <= rnd[24:22];
			bad_par <= k == 2;
			ph = k < 4 ? m + (k ? 18'h0 : v[3][17:0]) : {rnd[24:22], m[14:0]};
			setmar(m);
			blk_addr <= m;
			acc(1'h0, 1'h0, G_WORD, (k == 1 || k == 3) ? SRC_BLK : SRC_MAR, 3'h4, 5'h0, 2'h1, {ph[17:1], 1'h0},
				k == 2);
			rd(3'h4, word(ph));
		end
		{vm_enable, bad_par} <= 2'h2;
		// Byte and bit loads with clamped indexes, zero extended
		w = word(18'h0A5C3);
		setmar(18'h0A5C3);
		for (int k = 0; k < 8; k++) begin
			sb = k < 4 ? 5'(k) : 5'(k * 7 - 21);
			e = k < 4 ? 24'(w >> (8 * (sb > 2 ? 2 : sb))) & 24'hFF : 24'(w[sb > 23 ? 23 : sb]);
			acc(1'h0, 1'h0, k < 4 ? G_BYTE : G_BIT, SRC_MAR, 3'h4, sb, 2'h1, 18'h0A5C2, 1'h0);
			rd(3'h4, e);
		end
		// Double word store, read back as the odd word into the I/O register
		setmar(18'h00201);
		acc(1'h0, 1'h1, G_DWORD, SRC_MAR, 3'h1, 5'h0, 2'h1, 18'h00200, 1'h0);
		acc(1'h0, 1'h0, G_WORD, SRC_MAR, 3'h0, 5'h0, 2'h1, 18'h00200, 1'h0);
		cyc(2);
		cmp("io_word", 48'(v[2]), 48'(io_word));
		// User mode: mapped page, absent page, hidden timer register
		@(posedge sys_clk);
		monitor_mode <= 1'h0;
		{pt_we, pt_present, pt_idx, pt_frame} <= {2'h3, 6'h03, 8'hB7};
		@(posedge sys_clk);
		pt_we <= 1'h0;
		setmar(18'h00D55);
		acc(1'h0, 1'h0, G_WORD, SRC_MAR, 3'h4, 5'h0, 2'h1, 18'h2DD54, 1'h0);
		rd(3'h4, word(18'h2DD55));
		setmar(18'h01010);
		acc(1'h0, 1'h0, G_WORD, SRC_MAR, 3'h4, 5'h0, 2'h2, 18'h0, 1'h0);
		cmp("fault_page", 48'h4, 48'(fault_page));
		rd(3'h4, word(18'h2DD55));
		acc(1'h0, 1'h0, G_WORD, SRC_MAR, 3'h5, 5'h0, 2'h3, 18'h0, 1'h0);
		monitor_mode <= 1'h1;
		rd(3'h5, v[5]);
		conclude();
	end
endmodule // tb_mem_access_unit
`default_nettype wire
